//--- common/hppc_pkg.sv
package hppc_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int RESET_MIN_NS = 26_000;
	// least time rounds up to whole cycles
	localparam int RESET_MIN_CYC = (RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int SEL_W = 3;
	localparam int DATA_W = 8;
	localparam logic [3:0] PST_HALTED = 4'h5;

	typedef struct packed {
		logic host_acknowledge;
		logic interrupt_acknowledge;
		logic host_abort_request;
		logic host_reset_request;
		logic broadcast_select;
		logic [SEL_W-1:0] board_select_code;
	} hppc_link_in_s;

	typedef enum logic [1:0] {
		HPPC_IDLE = 2'b00,
		HPPC_REQ = 2'b01,
		HPPC_DRIVE = 2'b10
	} hppc_tx_e;
endpackage

//--- hw/hppc_ctrl.sv
// Functional notes
// - board holds byte undriven and raises request, shown only when selected
// - on host acknowledge drop request; drive byte while acknowledge stays high
// - host negates acknowledge; board releases data bus and finishes
// - interrupt: code behind buffer, request visible when selected, break line low
// - break line active low, open-collector, shared among boards
// - interrupt acknowledge clears break latch and releases break line
// - selected board drops interrupt request on interrupt acknowledge
// - selected abort pulse sets latch driving level 7 interrupt
// - abort latch held until software clears it, no timeout
// - selected reset request held over 26 us gives soft reset
// - reset request with interrupt acknowledge over 26 us gives hard reset
// - broadcast select with reset or abort hits every board
// - cpu run led while transfer low, dma led while strobe low
// - halt led when processor status decodes to halted
// - host nmi flag set on pulse rise, cleared by latch clear select
// - break flag set on board interrupt edge, cleared by break clear, drives line
// - level 7 request low when abort, nmi or breakpoint flag active
// - each push button debounced by a set/reset latch
// - soft reset sum is button, host soft reset or reset instruction
// - cpu reset on hard, button, host, power-up or watchdog reset
// - link handshake signals asserted high
`timescale 1ns/10ps
`default_nettype none
module hppc_ctrl
	import hppc_pkg::*;
#(
	parameter int RESET_CYCLES = RESET_MIN_CYC
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [hppc_pkg::SEL_W-1:0] board_address,
	input wire hppc_pkg::hppc_link_in_s link_in,
	input wire logic [hppc_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_start,
	output logic tx_busy,
	input wire logic [hppc_pkg::DATA_W-1:0] service_code,
	input wire logic int_start,
	output logic int_busy,
	output logic [hppc_pkg::DATA_W-1:0] link_data_o,
	output logic link_data_oe,
	output logic board_request,
	output logic board_interrupt_request,
	input wire logic shared_break_line_n_i,
	output logic shared_break_line_n_o,
	output logic shared_break_line_n_oe,
	input wire logic latch_clear_select_n,
	input wire logic breakpoint_n,
	input wire logic reset_button_a_n,
	input wire logic reset_button_b_n,
	input wire logic abort_button_a_n,
	input wire logic abort_button_b_n,
	input wire logic reset_instruction_out_n,
	input wire logic power_up_reset_n,
	input wire logic watchdog_reset_n,
	input wire logic transfer_in_progress_n,
	input wire logic address_strobe_n,
	input wire logic [3:0] processor_status,
	output logic level7_request_n_o,
	output logic level7_request_n_oe,
	output logic soft_reset_sum,
	output logic hard_reset_n_o,
	output logic hard_reset_n_oe,
	output logic cpu_reset_n,
	output logic cpu_run_led,
	output logic dma_run_led,
	output logic halt_led,
	output logic host_break_seen
);
	import hppc_pkg::*;

	// counter needs at least one cycle to reach
	if (RESET_CYCLES < 1)
	begin
		$error("RESET_CYCLES must be at least one");
	end

	localparam int LINK_W = $bits(hppc_link_in_s);
	localparam int CNT_W = $clog2(RESET_CYCLES + 2);

	logic [LINK_W-1:0] sync1_r;
	logic [LINK_W-1:0] sync2_r;
	hppc_link_in_s lk;
	logic brk_sync1_r;
	logic brk_sync2_r;
	logic selected;
	logic addressed_all;
	hppc_tx_e tx_state_r;
	hppc_tx_e int_state_r;
	logic [DATA_W-1:0] data_r;
	logic host_break_flag;
	logic host_nmi_flag;
	logic abort_flag;
	logic breakpoint_flag;
	logic reset_button_debounce;
	logic abort_button_debounce;
	logic nmi_pulse_d_r;
	logic bp_d_r;
	logic abort_deb_d_r;
	logic [CNT_W-1:0] rst_cnt_r;
	logic host_soft_reset;
	logic host_hard_reset;
	logic hard_reset_sum;
	logic abort_hit;
	logic host_nmi_pulse;
	logic break_clear;

	// two-stage synchroniser for all host inputs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			brk_sync1_r <= 1'b1;
			brk_sync2_r <= 1'b1;
		end
		else
		begin
			sync1_r <= link_in;
			sync2_r <= sync1_r;
			brk_sync1_r <= shared_break_line_n_i;
			brk_sync2_r <= brk_sync1_r;
		end
	end

	// struct view of the synchronised host bits
	assign lk = hppc_link_in_s'(sync2_r);
	assign host_break_seen = ~brk_sync2_r;
	assign selected = (lk.board_select_code == board_address);
	// broadcast reaches every board, select code ignored
	assign addressed_all = selected | lk.broadcast_select;

	// byte write to host
	// a tie with an interrupt start goes to the byte write
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_state_r <= HPPC_IDLE;
		end
		else
		begin
			unique case (tx_state_r)
				HPPC_IDLE:
					if (tx_start && int_state_r == HPPC_IDLE)
						tx_state_r <= HPPC_REQ;
				HPPC_REQ:
					if (selected && lk.host_acknowledge)
						tx_state_r <= HPPC_DRIVE;
				HPPC_DRIVE:
					if (!lk.host_acknowledge)
						tx_state_r <= HPPC_IDLE;
				default:
					tx_state_r <= HPPC_IDLE;
			endcase
		end
	end

	// interrupt to host
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			int_state_r <= HPPC_IDLE;
		end
		else
		begin
			unique case (int_state_r)
				HPPC_IDLE:
					// refused while a byte write runs or starts
					if (int_start && !tx_start && tx_state_r == HPPC_IDLE)
						int_state_r <= HPPC_REQ;
				HPPC_REQ:
					if (selected && lk.host_acknowledge)
						int_state_r <= HPPC_DRIVE;
				HPPC_DRIVE:
					if (selected && lk.interrupt_acknowledge)
						int_state_r <= HPPC_IDLE;
				default:
					int_state_r <= HPPC_IDLE;
			endcase
		end
	end

	// byte held behind the closed buffer until acknowledge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			data_r <= '0;
		else if (tx_state_r == HPPC_IDLE && int_state_r == HPPC_IDLE)
		begin
			if (tx_start)
				data_r <= tx_data;
			else if (int_start)
				data_r <= service_code;
		end
	end

	assign tx_busy = (tx_state_r != HPPC_IDLE);
	assign int_busy = (int_state_r != HPPC_IDLE);
	assign board_request = selected && tx_state_r == HPPC_REQ;
	assign board_interrupt_request = selected && int_state_r != HPPC_IDLE;
	// buffer opens only while selected and acknowledged
	assign link_data_o = data_r;
	assign link_data_oe = selected && lk.host_acknowledge &&
		(tx_state_r != HPPC_IDLE || int_state_r != HPPC_IDLE);

	// break flag: set on interrupt start, cleared by acknowledge or soft reset
	assign break_clear = (selected && lk.interrupt_acknowledge) | soft_reset_sum;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			host_break_flag <= 1'b0;
		else if (int_state_r == HPPC_IDLE && int_start && !tx_start && tx_state_r == HPPC_IDLE)
			host_break_flag <= 1'b1;
		else if (break_clear)
			host_break_flag <= 1'b0;
	end

	// open-collector emulation: drive low or let go
	assign shared_break_line_n_o = 1'b0;
	assign shared_break_line_n_oe = host_break_flag;

	// abort pulse edge and reset counting
	assign abort_hit = addressed_all && lk.host_abort_request;
	// counter saturates one past the limit, drops with the request
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_cnt_r <= '0;
		else if (addressed_all && lk.host_reset_request)
		begin
			if (rst_cnt_r <= CNT_W'(RESET_CYCLES))
				rst_cnt_r <= rst_cnt_r + 1'b1;
		end
		else
			rst_cnt_r <= '0;
	end

	// interrupt acknowledge turns soft reset into hard reset
	assign host_soft_reset = (rst_cnt_r > CNT_W'(RESET_CYCLES)) && !lk.interrupt_acknowledge;
	assign host_hard_reset = (rst_cnt_r > CNT_W'(RESET_CYCLES)) && lk.interrupt_acknowledge;
	// addressed abort request acts as the nmi pulse
	assign host_nmi_pulse = abort_hit;

	// flag edge detectors
	// reset values match the idle level of each source
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			nmi_pulse_d_r <= 1'b0;
			bp_d_r <= 1'b1;
			abort_deb_d_r <= 1'b0;
		end
		else
		begin
			nmi_pulse_d_r <= host_nmi_pulse;
			bp_d_r <= breakpoint_n;
			abort_deb_d_r <= abort_button_debounce;
		end
	end

	// set beats clear on every flag
	// clear is clocked; pins are taken as synchronous
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			host_nmi_flag <= 1'b0;
		else if (host_nmi_pulse && !nmi_pulse_d_r)
			host_nmi_flag <= 1'b1;
		else if (!latch_clear_select_n)
			host_nmi_flag <= 1'b0;
	end

	// breakpoint flag on falling edge of its request
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			breakpoint_flag <= 1'b0;
		else if (!breakpoint_n && bp_d_r)
			breakpoint_flag <= 1'b1;
		else if (!latch_clear_select_n)
			breakpoint_flag <= 1'b0;
	end

	// abort button flag on debounce rise
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			abort_flag <= 1'b0;
		else if (abort_button_debounce && !abort_deb_d_r)
			abort_flag <= 1'b1;
		else if (!latch_clear_select_n)
			abort_flag <= 1'b0;
	end

	// level 7 request pulled low through the enable only
	assign level7_request_n_o = 1'b0;
	assign level7_request_n_oe = abort_flag | host_nmi_flag | breakpoint_flag;

	// push-button set/reset latches
	// contact a sets, contact b clears
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reset_button_debounce <= 1'b0;
			abort_button_debounce <= 1'b0;
		end
		else
		begin
			if (!reset_button_a_n)
				reset_button_debounce <= 1'b1;
			else if (!reset_button_b_n)
				reset_button_debounce <= 1'b0;
			if (!abort_button_a_n)
				abort_button_debounce <= 1'b1;
			else if (!abort_button_b_n)
				abort_button_debounce <= 1'b0;
		end
	end

	assign soft_reset_sum = host_soft_reset | (reset_button_debounce & ~abort_button_debounce) |
		~reset_instruction_out_n;
	// both buttons held together give a hard reset
	assign hard_reset_sum = host_hard_reset | (reset_button_debounce & abort_button_debounce);
	// hard reset driver kept apart from the cpu reset
	assign hard_reset_n_o = 1'b0;
	assign hard_reset_n_oe = hard_reset_sum;
	// reset instruction resets peripherals, not the cpu
	assign cpu_reset_n = ~(hard_reset_sum | reset_button_debounce | host_soft_reset |
		~power_up_reset_n | ~watchdog_reset_n);

	// indicators
	assign cpu_run_led = ~transfer_in_progress_n;
	assign dma_run_led = ~address_strobe_n;
	assign halt_led = (processor_status == PST_HALTED);
endmodule
`default_nettype wire

//--- sim/hppc_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module hppc_ctrl_properties
	import hppc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire hppc_pkg::hppc_link_in_s link_in,
	input wire logic tx_start,
	input wire logic int_start,
	input wire logic tx_busy,
	input wire logic int_busy,
	input wire logic link_data_oe,
	input wire logic shared_break_line_n_o,
	input wire logic shared_break_line_n_oe,
	input wire logic latch_clear_select_n,
	input wire logic level7_request_n_oe,
	input wire logic transfer_in_progress_n,
	input wire logic address_strobe_n,
	input wire logic [3:0] processor_status,
	input wire logic cpu_run_led,
	input wire logic dma_run_led,
	input wire logic halt_led,
	input wire logic power_up_reset_n,
	input wire logic cpu_reset_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_idle;
		!tx_busy && !int_busy;
	endsequence
	property p_led;
		cpu_run_led == !transfer_in_progress_n && dma_run_led == !address_strobe_n;
	endproperty
	a_led: assert property (p_led) else $error("run led wrong");
	property p_halt;
		halt_led == (processor_status == 4'h5);
	endproperty
	a_halt: assert property (p_halt) else $error("halt led wrong");
	property p_tx;
		s_idle ##0 tx_start |=> tx_busy;
	endproperty
	a_tx: assert property (p_tx) else $error("byte write not taken");
	property p_int;
		s_idle ##0 int_start && !tx_start |=> shared_break_line_n_oe && int_busy;
	endproperty
	a_int: assert property (p_int) else $error("break line not pulled");
	property p_oc;
		shared_break_line_n_oe |-> !shared_break_line_n_o;
	endproperty
	a_oc: assert property (p_oc) else $error("break line drives high");
	property p_l7;
		level7_request_n_oe && latch_clear_select_n |=> level7_request_n_oe;
	endproperty
	a_l7: assert property (p_l7) else $error("level7 latch lost");
	property p_sync;
		$rose(link_data_oe) |-> $past(link_in.host_acknowledge, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("ack used unsynchronised");
	property p_busy;
		link_data_oe |-> tx_busy || int_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("bus driven when idle");
	property p_cpu;
		!power_up_reset_n |-> !cpu_reset_n;
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu reset missing");
endmodule
bind hppc_ctrl hppc_ctrl_properties hppc_ctrl_properties_i (.*);
`default_nettype wire

//--- sim/hppc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hppc_host_model
	import hppc_pkg::*;
(
	input wire logic clk,
	input wire logic slow,
	input wire logic [hppc_pkg::SEL_W-1:0] sel,
	input wire logic abort,
	input wire logic rst_req,
	input wire logic all,
	input wire logic hard,
	input wire logic board_request,
	input wire logic board_interrupt_request,
	input wire logic [hppc_pkg::DATA_W-1:0] bus,
	input wire logic break_n,
	output wire hppc_pkg::hppc_link_in_s link_in,
	output logic [hppc_pkg::DATA_W-1:0] got,
	output int got_cnt
);
	logic ack = 1'b0;
	logic ia = 1'b0;
	int i;
	// asserted high; select code addresses one board
	assign link_in = '{ack, ia | hard, abort, rst_req, all, sel};
	task xfer;
		repeat (slow ? 9 : 1) @(posedge clk);
		#1 ack = 1'b1;
		repeat (6) @(posedge clk);
		got = bus;
		got_cnt++;
		#1 ack = 1'b0;
		repeat (4) @(posedge clk);
	endtask
	initial
	begin
		got_cnt = 0;
		got = 8'h00;
		forever
		begin
			@(posedge clk);
			if (board_request)
				xfer();
			else if (!break_n && board_interrupt_request)
			begin
				xfer();
				#1 ia = 1'b1;
				for (i = 0; i < 20 && board_interrupt_request; i++)
					@(posedge clk);
				#1 ia = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/test_hppc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_hppc_ctrl;
	import hppc_pkg::*;
	localparam int RC = 10;
	logic clk = 0, rst_b = 0, tx_start = 0, int_start = 0, slow = 0, abort = 0, rst_req = 0, all = 0, hard = 0;
	logic latch_clear_select_n = 1, breakpoint_n = 1, reset_button_a_n = 1, reset_button_b_n = 1;
	logic abort_button_a_n = 1, abort_button_b_n = 1, reset_instruction_out_n = 1, power_up_reset_n = 1;
	logic watchdog_reset_n = 1, transfer_in_progress_n = 1, address_strobe_n = 1;
	logic [3:0] processor_status = 4'h0;
	logic [2:0] board_address = 3'h5, sel = 3'h2;
	logic [7:0] tx_data = 8'h00, service_code = 8'h00, got, link_data_o;
	logic [31:0] lfsr = 32'h00016F12;
	logic tx_busy, int_busy, link_data_oe, board_request, board_interrupt_request, shared_break_line_n_o;
	logic shared_break_line_n_oe, level7_request_n_o, level7_request_n_oe, soft_reset_sum, hard_reset_n_o;
	logic hard_reset_n_oe, cpu_reset_n, cpu_run_led, dma_run_led, halt_led, host_break_seen;
	int err_count = 0, checked = 0, got_cnt, n;
	logic [7:0] exp_q[$];
	hppc_link_in_s link_in;
	wire logic shared_break_line_n_i = !shared_break_line_n_oe;
	wire logic [7:0] bus = link_data_oe ? link_data_o : ~link_data_o;
	hppc_ctrl #(.RESET_CYCLES(RC)) hppc_ctrl_i (.*);
	hppc_host_model hppc_host_model_i (.clk, .slow, .sel, .abort, .rst_req, .all, .hard, .board_request,
		.board_interrupt_request, .bus, .break_n(shared_break_line_n_i), .link_in, .got, .got_cnt);
	always #10 clk = ~clk;
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task tk(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %0t saw %h want %h", $time, s, e);
		end
	endtask
	task wt;
		for (int k = 0; k < 300 && (tx_busy || int_busy); k++)
			tk(1);
		chk({tx_busy, int_busy}, 2'b00);
	endtask
	task clr;
		latch_clear_select_n = 0;
		tk(2);
		latch_clear_select_n = 1;
		tk(1);
		chk(level7_request_n_oe, 0);
	endtask
	task stop_test;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#400000;
		err_count++;
		stop_test();
	end
	initial
	begin
		tk(10);
		rst_b = 1;
		for (n = 0; n < 24; n++)
		begin
			lfsr = nxt(lfsr);
			{transfer_in_progress_n, address_strobe_n, processor_status} = (n == 3) ? 6'h05 : lfsr[5:0];
			tk(1);
			chk({cpu_run_led, dma_run_led, halt_led}, {!transfer_in_progress_n, !address_strobe_n, processor_status == 4'h5});
		end
		for (n = 0; n < 3; n++)
		begin
			lfsr = nxt(lfsr);
			tx_data = lfsr[7:0];
			exp_q.push_back(tx_data);
			slow = n[0];
			tx_start = 1;
			tk(1);
			tx_start = 0;
			tk(3);
			tx_data = ~tx_data;
			tx_start = 1;
			tk(1);
			tx_start = 0;
			if (n == 0)
			begin
				tk(20);
				chk(board_request, 0);
				sel = board_address;
			end
			wt();
			chk(got, exp_q.pop_front());
		end
		service_code = lfsr[15:8];
		int_start = 1;
		tk(1);
		int_start = 0;
		chk(shared_break_line_n_oe, 1);
		tk(2);
		chk({host_break_seen, level7_request_n_o, hard_reset_n_o, shared_break_line_n_o}, 8'h08);
		wt();
		chk(got, service_code);
		chk({got_cnt[5:0], shared_break_line_n_oe, board_interrupt_request}, 8'h10);
		for (n = 0; n < 3; n++)
		begin
			all = n[0];
			sel = n[0] ? ~board_address : board_address;
			abort = n < 2;
			breakpoint_n = n < 2;
			tk(1);
			{abort, breakpoint_n} = 2'b01;
			tk(6 + 50 * (n == 0));
			chk(level7_request_n_oe, 1);
			clr();
		end
		for (n = 0; n < 8; n++)
		begin
			{hard, all} = {n[2], n[1]};
			sel = n[1] ? ~board_address : board_address;
			rst_req = 1;
			tk(n[0] ? RC + 6 : RC - 4);
			chk({soft_reset_sum, hard_reset_n_oe, cpu_reset_n}, n[0] ? (n[2] ? 3'b010 : 3'b100) : 3'b001);
			{rst_req, hard, all} = 3'b000;
			tk(6);
		end
		reset_button_a_n = 0;
		tk(1);
		reset_button_a_n = 1;
		tk(1);
		chk({soft_reset_sum, cpu_reset_n}, 2'b10);
		reset_button_b_n = 0;
		tk(1);
		reset_button_b_n = 1;
		reset_instruction_out_n = 0;
		power_up_reset_n = 0;
		tk(1);
		chk({soft_reset_sum, cpu_reset_n}, 2'b10);
		{reset_instruction_out_n, power_up_reset_n, watchdog_reset_n} = 3'b110;
		tk(1);
		chk({soft_reset_sum, cpu_reset_n}, 2'b00);
		watchdog_reset_n = 1;
		abort_button_a_n = 0;
		tk(2);
		abort_button_a_n = 1;
		tk(2);
		chk(level7_request_n_oe, 1);
		abort_button_b_n = 0;
		tk(2);
		abort_button_b_n = 1;
		clr();
		stop_test();
	end
endmodule
`default_nettype wire
